// file: verilog/lcdc_column_driver.sv
// Top of the cascadable 128-column LCD segment driver
`timescale 1ns/1ns

// How it works
// - Direction high: right outputs, left inputs
// - Enable input low: stand-by, nothing loaded
// - Full with enable high raises enable output
// - Latch pulse clears every enable output
// - Thirty-two by four-bit bidirectional shift register
// - Direction picks input end and shift way
// - Latch falling edge copies into display latch
// - Data and phase pick one of four levels
// - Direction high: first data at column zero
// - Four-bit data, shift clock at most 4 MHz
// - No separate enable clock needed
// - 128 column outputs from latch bits
module lcdc_column_driver (
	input  wire logic                              clk,
	input  wire logic                              sys_rst,
	input  wire logic                              column_shift_clock,
	input  wire logic                              port_direction_select,
	input  wire logic                              line_latch_pulse,
	input  wire logic                              ac_drive_phase,
	input  wire logic [lcdc_pkg::NIBBLE_W-1:0]     display_data_lines_left_in,
	output logic      [lcdc_pkg::NIBBLE_W-1:0]     display_data_lines_left_out,
	output logic                                   display_data_lines_left_oe_n,
	input  wire logic [lcdc_pkg::NIBBLE_W-1:0]     display_data_lines_right_in,
	output logic      [lcdc_pkg::NIBBLE_W-1:0]     display_data_lines_right_out,
	output logic                                   display_data_lines_right_oe_n,
	input  wire logic                              chain_enable_left_in,
	output logic                                   chain_enable_left_out,
	output logic                                   chain_enable_left_oe_n,
	input  wire logic                              chain_enable_right_in,
	output logic                                   chain_enable_right_out,
	output logic                                   chain_enable_right_oe_n,
	output lcdc_pkg::lcdc_columns_type             column_outputs
);
	import lcdc_pkg::*;

	// ==========================================================
	// Functions
	function automatic lcdc_level_type level_of(input logic data_bit, input logic phase);
		lcdc_level_type lvl;
		unique case ({data_bit, phase})
			2'h3: lvl = LEVEL_TOP;
			2'h2: lvl = LEVEL_BOTTOM;
			2'h1: lvl = LEVEL_UPPER_MID;
			2'h0: lvl = LEVEL_LOWER_MID;
		endcase
		return lvl;
	endfunction

	// Column 4*i+j takes bit j of stage i, bit 3-j when reversed
	function automatic logic [NUM_COLUMNS-1:0] latch_image(
		input logic                dir_high,
		input logic [NIBBLE_W-1:0] words [NUM_STAGES]
	);
		logic [NUM_COLUMNS-1:0] img;
		img = LATCH_ZERO;
		for (int i = 0; i < NUM_STAGES; i++) begin
			for (int j = 0; j < NIBBLE_W; j++) begin
				img[i*NIBBLE_W+j] = dir_high ? words[i][j] : words[i][NIBBLE_W-1-j];
			end
		end
		return img;
	endfunction

	// ==========================================================
	// Pin synchronisers
	logic [PIN_W-1:0] pin_sync1;
	logic [PIN_W-1:0] pin_sync2;
	logic             dir;
	logic             latch_level;
	logic             phase;
	logic             enable_in;
	logic             latch_prev;
	logic             latch_fall;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pin_sync1 <= PIN_ZERO;
			pin_sync2 <= PIN_ZERO;
		end else begin
			pin_sync1 <= {port_direction_select, line_latch_pulse, ac_drive_phase,
				chain_enable_left_in, chain_enable_right_in};
			pin_sync2 <= pin_sync1;
		end
	end

	assign dir         = pin_sync2[PIN_DIR];
	assign latch_level = pin_sync2[PIN_LATCH];
	assign phase       = pin_sync2[PIN_PHASE];
	assign enable_in   = dir ? pin_sync2[PIN_EN_LEFT] : pin_sync2[PIN_EN_RGT];

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			latch_prev <= 1'b0;
		end else begin
			latch_prev <= latch_level;
		end
	end

	assign latch_fall = latch_prev & ~latch_level;

	// ==========================================================
	// Link crossing
	logic                beat_toggle;
	logic [NIBBLE_W-1:0] beat_data;
	logic                toggle_sync1;
	logic                toggle_sync2;
	logic                toggle_seen;
	logic                beat;

	lcdc_link_capture i_lcdc_link_capture (
		.column_shift_clock          (column_shift_clock),
		.sys_rst                     (sys_rst),
		.port_direction_select       (port_direction_select),
		.chain_enable_left_in        (chain_enable_left_in),
		.chain_enable_right_in       (chain_enable_right_in),
		.display_data_lines_left_in  (display_data_lines_left_in),
		.display_data_lines_right_in (display_data_lines_right_in),
		.beat_toggle                 (beat_toggle),
		.beat_data                   (beat_data)
	);

	// Seen copy follows the toggle during reset so no stale beat fires after
	always_ff @(posedge clk) begin
		toggle_sync1 <= beat_toggle;
		toggle_sync2 <= toggle_sync1;
		toggle_seen  <= toggle_sync2;
	end

	// Nibble is stable a full link period after its toggle, so it is read here
	assign beat = toggle_sync2 ^ toggle_seen;

	// ==========================================================
	// Line counter
	logic [COUNT_W-1:0] count;
	logic               full;
	logic               accept;

	assign full   = (count == COUNT_FULL);
	assign accept = beat & ~full & ~latch_level;

	always_ff @(posedge clk) begin
		if (sys_rst || latch_level) begin
			count <= COUNT_ZERO;
		end else if (accept) begin
			count <= count + COUNT_ONE;
		end
	end

	// ==========================================================
	// Shift register
	logic [NIBBLE_W-1:0] stages [NUM_STAGES];

	// bidirectional shift, way set by direction
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int i = 0; i < NUM_STAGES; i++) begin
				stages[i] <= NIBBLE_ZERO;
			end
		end else if (accept) begin
			if (dir) begin
				for (int i = 0; i < LAST_STAGE; i++) begin
					stages[i] <= stages[i+1];
				end
				stages[LAST_STAGE] <= beat_data;
			end else begin
				for (int i = 1; i < NUM_STAGES; i++) begin
					stages[i] <= stages[i-1];
				end
				stages[0] <= beat_data;
			end
		end
	end

	// ==========================================================
	// Display latch and column drive
	logic [NUM_COLUMNS-1:0] display_latch;

	// copy on latch falling edge, column order
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			display_latch <= LATCH_ZERO;
		end else if (latch_fall) begin
			display_latch <= latch_image(dir, stages);
		end
	end

	// one output per latch bit, level select
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			column_outputs <= lcdc_columns_type'({NUM_COLUMNS{LEVEL_LOWER_MID}});
		end else begin
			for (int c = 0; c < NUM_COLUMNS; c++) begin
				column_outputs[c] <= level_of(display_latch[c], phase);
			end
		end
	end

	// ==========================================================
	// Chain enable and port roles
	logic next_chain;

	// full and enabled, latch clears; no extra clock
	assign next_chain = ~latch_level & enable_in & full;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			chain_enable_right_out <= 1'b0;
			chain_enable_left_out  <= 1'b0;
		end else begin
			chain_enable_right_out <= dir & next_chain;
			chain_enable_left_out  <= ~dir & next_chain;
		end
	end

	// output enables follow direction, low while driving
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			chain_enable_right_oe_n       <= 1'b1;
			chain_enable_left_oe_n        <= 1'b1;
			display_data_lines_right_oe_n <= 1'b1;
			display_data_lines_left_oe_n  <= 1'b1;
		end else begin
			chain_enable_right_oe_n       <= ~dir;
			chain_enable_left_oe_n        <= dir;
			display_data_lines_right_oe_n <= ~dir;
			display_data_lines_left_oe_n  <= dir;
		end
	end

	// Repeated data lags the bus; downstream drivers should share the bus instead
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			display_data_lines_right_out <= NIBBLE_ZERO;
			display_data_lines_left_out  <= NIBBLE_ZERO;
		end else if (beat) begin
			display_data_lines_right_out <= beat_data;
			display_data_lines_left_out  <= beat_data;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	property p_port_roles;
		dir && $past(dir) |-> !chain_enable_right_oe_n && chain_enable_left_oe_n
			&& !display_data_lines_right_oe_n && display_data_lines_left_oe_n;
	endproperty
	a_port_roles: assert property (p_port_roles) else $error("port roles disagree with direction");

	sequence s_fill_last;
		accept && count == COUNT_LAST ##1 full;
	endsequence

	property p_chain_rises;
		s_fill_last ##0 (enable_in && !latch_level)
			|=> (dir ? chain_enable_right_out : chain_enable_left_out);
	endproperty
	a_chain_rises: assert property (p_chain_rises) else $error("chain enable did not rise when full");

	property p_chain_clears;
		latch_level |=> !chain_enable_right_out && !chain_enable_left_out;
	endproperty
	a_chain_clears: assert property (p_chain_clears) else $error("latch pulse did not clear chain enable");

	property p_full_at_32;
		accept && count == COUNT_LAST && !latch_level |=> full ##1 (full || $past(latch_level));
	endproperty
	a_full_at_32: assert property (p_full_at_32) else $error("register not full after 32 shifts");

	property p_no_load_full;
		full && !latch_level |=> $stable(count) && stages[0] == $past(stages[0]);
	endproperty
	a_no_load_full: assert property (p_no_load_full) else $error("data loaded into full register");

	property p_shift_end;
		accept |=> (($past(dir) && stages[LAST_STAGE] == $past(beat_data))
			|| (!$past(dir) && stages[0] == $past(beat_data)));
	endproperty
	a_shift_end: assert property (p_shift_end) else $error("nibble entered at wrong end");

	property p_latch_copy;
		latch_fall && !accept |=> display_latch == latch_image($past(dir), stages);
	endproperty
	a_latch_copy: assert property (p_latch_copy) else $error("display latch not copied on falling edge");

	property p_first_column;
		latch_fall && dir |=> display_latch[NIBBLE_W-1:0] == $past(stages[0]);
	endproperty
	a_first_column: assert property (p_first_column) else $error("column zero order wrong");

	property p_level_select;
		##1 column_outputs[0] == level_of($past(display_latch[0]), $past(phase))
			&& column_outputs[NUM_COLUMNS-1] == level_of($past(display_latch[NUM_COLUMNS-1]), $past(phase));
	endproperty
	a_level_select: assert property (p_level_select) else $error("column drive level mismatch");

endmodule

// file: verilog/lcdc_pkg.sv
// Shared constants and types for the cascadable LCD column driver
package lcdc_pkg;

	// ==========================================================
	// Geometry
	localparam int NIBBLE_W    = 4;
	localparam int NUM_STAGES  = 32;
	localparam int NUM_COLUMNS = NUM_STAGES * NIBBLE_W;
	localparam int COUNT_W     = 6;
	localparam int LAST_STAGE  = NUM_STAGES - 1;

	localparam logic [COUNT_W-1:0] COUNT_ZERO = 6'h00;
	localparam logic [COUNT_W-1:0] COUNT_ONE  = 6'h01;
	localparam logic [COUNT_W-1:0] COUNT_LAST = 6'h1F;
	localparam logic [COUNT_W-1:0] COUNT_FULL = 6'h20;

	localparam logic [NIBBLE_W-1:0] NIBBLE_ZERO = 4'h0;
	localparam logic [NUM_COLUMNS-1:0] LATCH_ZERO = 128'h0;

	// ==========================================================
	// Pin synchroniser layout in the system clock domain
	localparam int PIN_W       = 5;
	localparam int PIN_DIR     = 4;
	localparam int PIN_LATCH   = 3;
	localparam int PIN_PHASE   = 2;
	localparam int PIN_EN_LEFT = 1;
	localparam int PIN_EN_RGT  = 0;

	localparam logic [PIN_W-1:0] PIN_ZERO = 5'h00;

	// ==========================================================
	// Link rate limit
	localparam int SHIFT_CLOCK_MAX_KHZ = 4000;
	localparam int SYS_CLOCK_KHZ       = 50000;
	localparam int SHIFT_PERIOD_MIN_CYCLES =
		(SYS_CLOCK_KHZ + SHIFT_CLOCK_MAX_KHZ - 1) / SHIFT_CLOCK_MAX_KHZ;

	// ==========================================================
	// Column drive levels
	typedef enum logic [1:0] {
		LEVEL_TOP,
		LEVEL_UPPER_MID,
		LEVEL_LOWER_MID,
		LEVEL_BOTTOM
	} lcdc_level_type;

	typedef lcdc_level_type [NUM_COLUMNS-1:0] lcdc_columns_type;

endpackage

// file: verilog/lcdc_link_capture.sv
// Shift-clock domain capture of display nibbles for the column driver
`timescale 1ns/1ns

module lcdc_link_capture (
	input  wire logic                              column_shift_clock,
	input  wire logic                              sys_rst,
	input  wire logic                              port_direction_select,
	input  wire logic                              chain_enable_left_in,
	input  wire logic                              chain_enable_right_in,
	input  wire logic [lcdc_pkg::NIBBLE_W-1:0]     display_data_lines_left_in,
	input  wire logic [lcdc_pkg::NIBBLE_W-1:0]     display_data_lines_right_in,
	output logic                                   beat_toggle,
	output logic [lcdc_pkg::NIBBLE_W-1:0]          beat_data
);
	import lcdc_pkg::*;

	// ==========================================================
	// Reset and strap synchronisers
	logic rst_sync1;
	logic rst_sync2;
	logic dir_sync1;
	logic dir_sync2;
	logic enable_selected;

	always_ff @(posedge column_shift_clock) begin
		rst_sync1 <= sys_rst;
		rst_sync2 <= rst_sync1;
		dir_sync1 <= port_direction_select;
		dir_sync2 <= dir_sync1;
	end

	// ==========================================================
	// Capture
	// input side chosen by direction
	assign enable_selected = dir_sync2 ? chain_enable_left_in : chain_enable_right_in;

	// Enable and data are set up to this clock, so they are sampled directly
	// no capture while enable low
	always_ff @(posedge column_shift_clock) begin
		if (rst_sync2) begin
			beat_toggle <= 1'b0;
			beat_data   <= NIBBLE_ZERO;
		end else if (enable_selected) begin
			beat_toggle <= ~beat_toggle;
			beat_data   <= dir_sync2 ? display_data_lines_left_in : display_data_lines_right_in;
		end
	end

	// ==========================================================
	// Checks
	property p_standby_holds;
		@(posedge column_shift_clock) disable iff (rst_sync2)
		!enable_selected |=> $stable(beat_toggle) && $stable(beat_data);
	endproperty
	a_standby_holds: assert property (p_standby_holds) else $error("beat taken while in stand-by");

endmodule

// file: tb/lcdc_ctrl_model.sv
// Partner model: display controller driving shift clock and data nibbles
`timescale 1ns/1ns

module lcdc_ctrl_model (
	output logic                          column_shift_clock,
	output logic [lcdc_pkg::NIBBLE_W-1:0] display_data_lines
);
	import lcdc_pkg::*;

	localparam time HALF = 80;

	initial begin
		column_shift_clock = 1'b0;
		display_data_lines = NIBBLE_ZERO;
	end

	// ==========================================================
	// Link traffic
	// four-bit nibble per rise
	task automatic send(input int first, input int count, input logic [3:0] seed);
		for (int k = first; k < first + count; k++) begin
			display_data_lines = seed + 4'(k * 7);
			#HALF column_shift_clock = 1'b1;
			#HALF column_shift_clock = 1'b0;
		end
		// Released lines must not keep the last nibble
		display_data_lines = ~display_data_lines;
	endtask

	// Idle pulses so the link side sees reset
	task automatic pulse(input int count);
		repeat (count) begin
			#HALF column_shift_clock = 1'b1;
			#HALF column_shift_clock = 1'b0;
		end
	endtask
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the cascadable LCD column driver
`timescale 1ns/1ns

`define CHK(what, exp, got) \
	begin \
		checked++; \
		if ((got) !== (exp)) begin \
			errors++; \
			$display("unexpected %s: expected %h, seen %h", what, exp, got); \
		end \
	end

module tb_top;
	import lcdc_pkg::*;

	logic                clk = 1'b0;
	logic                sys_rst = 1'b1;
	logic                dir = 1'b1;
	logic                latch = 1'b0;
	logic                phase = 1'b1;
	logic                en_in = 1'b1;
	int                  errors = 0;
	int                  checked = 0;
	wire                 shift_clk;
	wire  [NIBBLE_W-1:0] ctrl_data, left_in, left_out, right_in, right_out;
	wire                 left_oe_n, right_oe_n;
	wire                 en_left_in, en_left_out, en_left_oe_n;
	wire                 en_right_in, en_right_out, en_right_oe_n;
	lcdc_columns_type    cols;

	always #10 clk = ~clk;

	// ==========================================================
	// Wire levels: the party with enable low drives
	// first driver's enable driven from en_in
	assign left_in      = left_oe_n ? (dir ? ctrl_data : ~ctrl_data) : left_out;
	assign right_in     = right_oe_n ? (dir ? ~ctrl_data : ctrl_data) : right_out;
	assign en_left_in   = en_left_oe_n ? (dir & en_in) : en_left_out;
	assign en_right_in  = en_right_oe_n ? (~dir & en_in) : en_right_out;

	lcdc_ctrl_model i_lcdc_ctrl_model (
		.column_shift_clock (shift_clk),
		.display_data_lines (ctrl_data)
	);

	lcdc_column_driver i_lcdc_column_driver (
		.clk                           (clk),
		.sys_rst                       (sys_rst),
		.column_shift_clock            (shift_clk),
		.port_direction_select         (dir),
		.line_latch_pulse              (latch),
		.ac_drive_phase                (phase),
		.display_data_lines_left_in    (left_in),
		.display_data_lines_left_out   (left_out),
		.display_data_lines_left_oe_n  (left_oe_n),
		.display_data_lines_right_in   (right_in),
		.display_data_lines_right_out  (right_out),
		.display_data_lines_right_oe_n (right_oe_n),
		.chain_enable_left_in          (en_left_in),
		.chain_enable_left_out         (en_left_out),
		.chain_enable_left_oe_n        (en_left_oe_n),
		.chain_enable_right_in         (en_right_in),
		.chain_enable_right_out        (en_right_out),
		.chain_enable_right_oe_n       (en_right_oe_n),
		.column_outputs                (cols)
	);

	// ==========================================================
	// Helpers
	function automatic lcdc_columns_type expect_cols(input logic [3:0] seed, input logic d, input logic ph);
		lcdc_columns_type e;
		logic [3:0]       n;
		int               p;
		for (int c = 0; c < NUM_COLUMNS; c++) begin
			p = d ? c : NUM_COLUMNS - 1 - c;
			n = seed + 4'(p / 4 * 7);
			e[c] = n[p % 4] ? (ph ? LEVEL_TOP : LEVEL_BOTTOM) : (ph ? LEVEL_UPPER_MID : LEVEL_LOWER_MID);
		end
		return e;
	endfunction

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic pulse_latch();
		@(posedge clk) latch <= 1'b1;
		settle(5);
		`CHK("enable out in latch", 1'b0, dir ? en_right_out : en_left_out)
		@(posedge clk) latch <= 1'b0;
		settle(8);
	endtask

	task automatic wrap_up();
		$display("checks %0d, errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	task automatic run_line(input logic d, input logic [3:0] seed);
		logic turn;
		turn = (d != dir);
		@(posedge clk) dir <= d;
		settle(6);
		// Link side takes a new direction only on shift edges
		if (turn)
			i_lcdc_ctrl_model.pulse(2);
		`CHK("oe_n roles", {d, d, ~d, ~d}, {left_oe_n, en_left_oe_n, right_oe_n, en_right_oe_n})
		i_lcdc_ctrl_model.send(0, 31, seed);
		settle(10);
		`CHK("enable out after 31", 1'b0, d ? en_right_out : en_left_out)
		i_lcdc_ctrl_model.send(31, 1, seed);
		settle(10);
		`CHK("enable out after 32", 1'b1, d ? en_right_out : en_left_out)
		`CHK("repeated nibble", seed + 4'(31 * 7), d ? right_out : left_out)
		pulse_latch();
		for (int ph = 0; ph < 2; ph++) begin
			@(posedge clk) phase <= ph[0];
			settle(6);
			`CHK("columns", expect_cols(seed, d, ph[0]), cols)
		end
	endtask

	// Enable low: line ignored, old picture kept
	task automatic standby(input logic [3:0] old_seed);
		@(posedge clk) en_in <= 1'b0;
		i_lcdc_ctrl_model.send(0, 32, 4'h9);
		settle(10);
		`CHK("enable out in stand-by", 1'b0, dir ? en_right_out : en_left_out)
		pulse_latch();
		`CHK("columns in stand-by", expect_cols(old_seed, dir, phase), cols)
		@(posedge clk) en_in <= 1'b1;
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		// Link side resets only on shift edges
		fork
			repeat (6) @(posedge clk);
			i_lcdc_ctrl_model.pulse(3);
		join
		#1;
		`CHK("columns in reset", {NUM_COLUMNS{LEVEL_LOWER_MID}}, cols)
		`CHK("oe_n in reset", 4'hF, {left_oe_n, en_left_oe_n, right_oe_n, en_right_oe_n})
		@(posedge clk) sys_rst <= 1'b0;
		// Link side leaves reset on two idle shift edges
		i_lcdc_ctrl_model.pulse(2);
		run_line(1'b1, 4'h3);
		run_line(1'b0, 4'hA);
		standby(4'hA);
		wrap_up();
	end

	initial begin
		#200000;
		errors++;
		wrap_up();
	end
endmodule
